// [ep0_control_irq.sv]
/*
  Endpoint 0 control interrupt status registers and the second endpoint
  status register, behind an AXI4-Lite slave.
  Assumes events arrive as one-cycle pulses from logic on clk_sys_in and
  the setup data buffer bytes come in from the protocol engine.
*/
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
// Overview of operation
// [R1] Status-stage flag set on status stage entry
// [R2] Also set for no-data transfers
// [R3] Next SETUP token clears status-stage flag
// [R4] Set even when data-stage ACK lost
// [R5] Then clear transmit-ready once buffer cleared
// [R6] SETUP-received flag set on good setup
// [R7] Firmware clears it at first buffer read
// [R8] Left set, later SETUPs not seen
// [R9] Hardware repeat: no decode flag, setup flag
// [R10] Decode flag set for firmware request
// [R11] Decode flag cleared after all bytes read
// [R12] Line two fires on status two change
// [R13] Status two read-only, whole byte only
// [R14] Firmware reads status two to find source
// [R15] Zero written to clear two clears bit
// [R16] Unsupported endpoint bits read invalid
// [R17] Line one fires on status one change
// [R18] Zero written to clear one clears bit
`timescale 1ns/1ps
`default_nettype none

module ep0_control_irq (
  input  wire logic                      clk_sys_in,      // System clock, 125 MHz
  input  wire logic                      reset_in,        // Async reset, active high
  input  wire ep0_irq_pkg::usb_events_t  events_in,       // Protocol engine pulses
  input  wire logic [63:0]               setup_bytes_in,  // Setup buffer contents
  input  wire logic [7:0]                s_axi_awaddr,    // Write address
  input  wire logic                      s_axi_awvalid,   // Write address valid
  output logic                           s_axi_awready,   // Write address ready
  input  wire logic [31:0]               s_axi_wdata,     // Write data
  input  wire logic [3:0]                s_axi_wstrb,     // Write strobes
  input  wire logic                      s_axi_wvalid,    // Write data valid
  output logic                           s_axi_wready,    // Write data ready
  output logic [1:0]                     s_axi_bresp,     // Write response
  output logic                           s_axi_bvalid,    // Write response valid
  input  wire logic                      s_axi_bready,    // Write response ready
  input  wire logic [7:0]                s_axi_araddr,    // Read address
  input  wire logic                      s_axi_arvalid,   // Read address valid
  output logic                           s_axi_arready,   // Read address ready
  output logic [31:0]                    s_axi_rdata,     // Read data
  output logic [1:0]                     s_axi_rresp,     // Read response
  output logic                           s_axi_rvalid,    // Read data valid
  input  wire logic                      s_axi_rready,    // Read data ready
  output logic                           ep0_transmit_ready_out, // Endpoint 0 TX armed
  output logic                           usb_irq_line_one_out,   // Pulse on status one change
  output logic                           usb_irq_line_two_out,   // Pulse on status two change
  output logic                           irq_out          // Masked sticky interrupt
);

  // ************************************************
  // State
  // ************************************************
  logic [7:0] status_one_r, status_one_nxt;
  logic [7:0] status_two_r, status_two_nxt;
  logic [7:0] control_r;
  logic [1:0] irq_status_r, irq_status_nxt;
  logic [1:0] irq_mask_r;
  logic [3:0] setup_idx_r, setup_idx_nxt;
  logic       ack_lost_pend_r, ack_lost_pend_nxt;
  logic       aw_held_r, w_held_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;

  // ************************************************
  // Bus decode
  // ************************************************
  wire aw_take   = s_axi_awvalid & s_axi_awready;
  wire w_take    = s_axi_wvalid & s_axi_wready;
  wire aw_have   = aw_held_r | aw_take;
  wire w_have    = w_held_r | w_take;
  wire wr_fire   = aw_have & w_have & ~s_axi_bvalid;
  wire [7:0]  wr_addr = aw_held_r ? aw_addr_r : s_axi_awaddr;
  wire [31:0] wr_data = w_held_r ? w_data_r : s_axi_wdata;
  wire [3:0]  wr_strb = w_held_r ? w_strb_r : s_axi_wstrb;
  wire rd_fire   = s_axi_arvalid & s_axi_arready;

  // Byte-wide registers answer only writes that carry lane 0
  wire wr_lane0  = wr_fire & wr_strb[0];
  wire wr_clr1   = wr_lane0 & (wr_addr == ep0_irq_pkg::OFF_CLEAR_ONE);     // [R18]
  wire wr_clr2   = wr_lane0 & (wr_addr == ep0_irq_pkg::OFF_CLEAR_TWO);     // [R15]
  wire wr_ctl    = wr_lane0 & (wr_addr == ep0_irq_pkg::OFF_CONTROL);
  wire wr_irqs   = wr_lane0 & (wr_addr == ep0_irq_pkg::OFF_IRQ_STATUS);
  wire wr_mask   = wr_lane0 & (wr_addr == ep0_irq_pkg::OFF_IRQ_MASK);
  wire wr_known  = wr_addr inside {ep0_irq_pkg::OFF_CLEAR_ONE, ep0_irq_pkg::OFF_CLEAR_TWO,
                                   ep0_irq_pkg::OFF_CONTROL, ep0_irq_pkg::OFF_IRQ_STATUS,
                                   ep0_irq_pkg::OFF_IRQ_MASK};

  wire rd_setup  = rd_fire & (s_axi_araddr == ep0_irq_pkg::OFF_SETUP_BUF);

  // ************************************************
  // Status one flags
  // ************************************************
  wire setup_tok = events_in.setup_token;
  wire ev_stage  = events_in.status_stage;                                  // [R1] [R2] [R4]
  wire ev_setup  = events_in.setup_data_ok;                                 // [R6] [R8]
  // A hardware-handled repeat never asserts fw_request, so only setup flag rises
  wire ev_decode = events_in.setup_data_ok & events_in.fw_request;          // [R9] [R10]
  wire first_rd  = rd_setup & (setup_idx_r == ep0_irq_pkg::SETUP_IDX_RST);
  wire last_rd   = rd_setup & (setup_idx_r == ep0_irq_pkg::SETUP_LAST);

  always_comb begin
    status_one_nxt = status_one_r;
    if (wr_clr1) begin
      status_one_nxt = status_one_nxt & wr_data[7:0];                       // [R18]
    end
    if (setup_tok) begin
      status_one_nxt[ep0_irq_pkg::BIT_STAGE] = 1'b0;                        // [R3]
    end
    if (first_rd) begin
      status_one_nxt[ep0_irq_pkg::BIT_SETUP] = 1'b0;                        // [R7]
    end
    if (last_rd) begin
      status_one_nxt[ep0_irq_pkg::BIT_DECODE] = 1'b0;                       // [R11]
    end
    // Events applied last so a set wins over any clear in the same cycle
    if (ev_stage) begin
      status_one_nxt[ep0_irq_pkg::BIT_STAGE] = 1'b1;                        // [R1]
    end
    if (ev_setup) begin
      status_one_nxt[ep0_irq_pkg::BIT_SETUP] = 1'b1;                        // [R6]
    end
    if (ev_decode) begin
      status_one_nxt[ep0_irq_pkg::BIT_DECODE] = 1'b1;                       // [R10]
    end
  end

  // Setup buffer read index, restarted by every fresh setup packet
  always_comb begin
    setup_idx_nxt = setup_idx_r;
    if (ev_setup) begin
      setup_idx_nxt = ep0_irq_pkg::SETUP_IDX_RST;
    end else if (last_rd) begin
      setup_idx_nxt = ep0_irq_pkg::SETUP_IDX_RST;
    end else if (rd_setup) begin
      setup_idx_nxt = setup_idx_r + 4'h1;
    end
  end

  // ************************************************
  // Transmit-ready handling after a lost data ACK
  // ************************************************
  wire ack_lost_read = ev_stage & events_in.data_ack_lost & events_in.ctrl_read;
  always_comb begin
    ack_lost_pend_nxt = ack_lost_pend_r;
    if (ack_lost_read) begin
      ack_lost_pend_nxt = 1'b1;
    end else if (events_in.tx_buf_cleared | setup_tok) begin
      ack_lost_pend_nxt = 1'b0;
    end
  end
  wire drop_ready = (ack_lost_pend_r | ack_lost_read) & events_in.tx_buf_cleared; // [R5]

  // ************************************************
  // Status two flags
  // ************************************************
  wire ep1_ok = control_r[ep0_irq_pkg::CTL_EP1_EN];
  always_comb begin
    status_two_nxt = status_two_r;
    if (wr_clr2) begin
      status_two_nxt = status_two_nxt & wr_data[7:0];                       // [R15]
    end
    if (events_in.bulk_in_nak) begin
      status_two_nxt[ep0_irq_pkg::BIT_BULK_IN] = 1'b1;
    end
    if (events_in.bulk_data_done) begin
      status_two_nxt[ep0_irq_pkg::BIT_BULK_DT] = 1'b1;
    end
    // Unsupported endpoint bits never hold a value
    status_two_nxt = status_two_nxt & (ep1_ok ? ep0_irq_pkg::VALID_TWO : 8'h00); // [R16]
  end

  wire chg_one = status_one_nxt != status_one_r;                            // [R17]
  wire chg_two = status_two_nxt != status_two_r;                            // [R12]

  // Sticky summary: a change sets, write-one clears, set wins
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (wr_irqs) begin
      irq_status_nxt = irq_status_r & ~wr_data[1:0];
    end
    irq_status_nxt = irq_status_nxt | {chg_two, chg_one};
  end

  // ************************************************
  // Read mux
  // ************************************************
  logic [31:0] rd_mux;
  logic        rd_err;
  always_comb begin
    rd_mux = 32'h0;
    rd_err = 1'b0;
    case (s_axi_araddr)
      ep0_irq_pkg::OFF_STATUS_ONE: rd_mux = {24'h0, status_one_r};
      ep0_irq_pkg::OFF_STATUS_TWO: rd_mux = {24'h0, status_two_r};         // [R13] [R14]
      ep0_irq_pkg::OFF_SETUP_BUF:  rd_mux = {24'h0, setup_bytes_in[{setup_idx_r[2:0], 3'b000} +: 8]};
      ep0_irq_pkg::OFF_CONTROL:    rd_mux = {24'h0, control_r};
      ep0_irq_pkg::OFF_IRQ_STATUS: rd_mux = {30'h0, irq_status_r};
      ep0_irq_pkg::OFF_IRQ_MASK:   rd_mux = {30'h0, irq_mask_r};
      ep0_irq_pkg::OFF_CLEAR_ONE,
      ep0_irq_pkg::OFF_CLEAR_TWO:  rd_mux = 32'h0;
      default:                     rd_err = 1'b1;
    endcase
  end

  // ************************************************
  // Flip-flops
  // ************************************************
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      status_one_r    <= ep0_irq_pkg::STATUS_RESET;
      status_two_r    <= ep0_irq_pkg::STATUS_RESET;
      irq_status_r    <= ep0_irq_pkg::IRQ_RESET;
      setup_idx_r     <= ep0_irq_pkg::SETUP_IDX_RST;
      ack_lost_pend_r <= 1'b0;
      usb_irq_line_one_out <= 1'b0;
      usb_irq_line_two_out <= 1'b0;
      irq_out         <= 1'b0;
    end else begin
      status_one_r    <= status_one_nxt;
      status_two_r    <= status_two_nxt;
      irq_status_r    <= irq_status_nxt;
      setup_idx_r     <= setup_idx_nxt;
      ack_lost_pend_r <= ack_lost_pend_nxt;
      usb_irq_line_one_out <= chg_one;                                      // [R17]
      usb_irq_line_two_out <= chg_two;                                      // [R12]
      irq_out         <= |(irq_status_nxt & irq_mask_r);
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      control_r  <= ep0_irq_pkg::CTL_RESET;
      irq_mask_r <= ep0_irq_pkg::IRQ_RESET;
      ep0_transmit_ready_out <= 1'b0;
    end else begin
      if (wr_ctl) begin
        control_r <= wr_data[7:0];
      end
      // Keep the readable transmit-ready bit in step with the output
      if (drop_ready) begin
        control_r[ep0_irq_pkg::CTL_TX_READY] <= 1'b0;                       // [R5]
      end
      if (wr_mask) begin
        irq_mask_r <= wr_data[1:0];
      end
      // Firmware arms the transmitter; hardware drops it after a lost ACK
      if (drop_ready) begin
        ep0_transmit_ready_out <= 1'b0;                                     // [R5]
      end else if (wr_ctl) begin
        ep0_transmit_ready_out <= wr_data[ep0_irq_pkg::CTL_TX_READY];
      end
    end
  end

  // ************************************************
  // AXI4-Lite handshakes
  // ************************************************
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= ep0_irq_pkg::RESP_OKAY;
    end else begin
      // Ready is withheld while a word is parked or a response is pending
      s_axi_awready <= ~aw_have & ~s_axi_bvalid & ~s_axi_awready;
      s_axi_wready  <= ~w_have & ~s_axi_bvalid & ~s_axi_wready;
      if (aw_take) begin
        aw_addr_r <= s_axi_awaddr;
      end
      if (w_take) begin
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      aw_held_r <= aw_have & ~wr_fire;
      w_held_r  <= w_have & ~wr_fire;
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_known ? ep0_irq_pkg::RESP_OKAY : ep0_irq_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= ep0_irq_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_err ? ep0_irq_pkg::RESP_SLVERR : ep0_irq_pkg::RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // ep0_control_irq

`default_nettype wire

// [ep0_irq_pkg.sv]
/*
  Package for the endpoint 0 control interrupt status block: register
  offsets, bit positions, reset values and the event carrier struct.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
`default_nettype none

package ep0_irq_pkg;

  // ************************************************
  // Register byte offsets
  // ************************************************
  localparam logic [7:0] OFF_STATUS_ONE = 8'h00;
  localparam logic [7:0] OFF_STATUS_TWO = 8'h04;
  localparam logic [7:0] OFF_CLEAR_ONE  = 8'h08;
  localparam logic [7:0] OFF_CLEAR_TWO  = 8'h0C;
  localparam logic [7:0] OFF_SETUP_BUF  = 8'h10;
  localparam logic [7:0] OFF_CONTROL    = 8'h14;
  localparam logic [7:0] OFF_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK   = 8'h1C;

  // ************************************************
  // Field positions
  // ************************************************
  localparam int BIT_DECODE   = 0;
  localparam int BIT_SETUP    = 1;
  localparam int BIT_STAGE    = 2;
  localparam int BIT_BULK_DT  = 4;
  localparam int BIT_BULK_IN  = 5;
  localparam int CTL_TX_READY = 0;
  localparam int CTL_EP1_EN   = 1;

  // ************************************************
  // Reset values and widths
  // ************************************************
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  VALID_TWO     = 8'h30;
  localparam logic [7:0]  CTL_RESET     = 8'h00;
  localparam logic [1:0]  IRQ_RESET     = 2'h0;
  localparam logic [3:0]  SETUP_LAST    = 4'h7;
  localparam logic [3:0]  SETUP_IDX_RST = 4'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  // ************************************************
  // Event carrier from the USB protocol engine
  // ************************************************
  typedef struct packed {
    logic setup_token;     // SETUP token seen
    logic setup_data_ok;   // Setup buffer filled correctly
    logic fw_request;      // Request needs firmware decode
    logic status_stage;    // Transfer entered status stage
    logic data_ack_lost;   // Data-stage ACK was not received
    logic tx_buf_cleared;  // Endpoint 0 transmit buffer emptied
    logic ctrl_read;       // Firmware handles a control read
    logic bulk_in_nak;     // Bulk IN token answered with NAK
    logic bulk_data_done;  // Bulk transmission completed
  } usb_events_t;

endpackage

`default_nettype wire

// [ep0_irq_properties.sv]
/* Concurrent checks on the ports of ep0_control_irq.
   Bound to every instance of that module; one clock, one async reset. */
`timescale 1ns/1ps
`default_nettype none
module ep0_irq_properties (
  input wire logic                     clk_sys_in,             // System clock
  input wire logic                     reset_in,               // Async reset
  input wire ep0_irq_pkg::usb_events_t events_in,              // Engine pulses
  input wire logic [7:0]               s_axi_awaddr,           // Write address
  input wire logic                     s_axi_awvalid,          // Write address valid
  input wire logic                     s_axi_awready,          // Write address ready
  input wire logic [1:0]               s_axi_bresp,            // Write response
  input wire logic                     s_axi_bvalid,           // Write response valid
  input wire logic [7:0]               s_axi_araddr,           // Read address
  input wire logic                     s_axi_arvalid,          // Read address valid
  input wire logic                     s_axi_arready,          // Read address ready
  input wire logic [31:0]              s_axi_rdata,            // Read data
  input wire logic [1:0]               s_axi_rresp,            // Read response
  input wire logic                     s_axi_rvalid,           // Read data valid
  input wire logic                     ep0_transmit_ready_out, // Endpoint 0 TX armed
  input wire logic                     usb_irq_line_one_out,   // Status one change
  input wire logic                     usb_irq_line_two_out,   // Status two change
  input wire logic                     irq_out                 // Masked interrupt
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);
  // ************************************************
  // Status-stage flag sequences
  // ************************************************
  // After a lone SETUP token the stage flag is known clear, so a set must show
  sequence s_fresh_token;
    events_in.setup_token && !events_in.status_stage ##1 !events_in.status_stage;
  endsequence
  sequence s_stage_then_token;
    events_in.status_stage && !events_in.setup_token
      ##1 events_in.setup_token && !events_in.status_stage;
  endsequence
  property p_stage_line;
    s_fresh_token ##1 events_in.status_stage |=> usb_irq_line_one_out;
  endproperty
  a_stage_line: assert property (p_stage_line) else $error("stage entry not signalled");
  property p_lost_ack_line;
    s_fresh_token ##1 (events_in.status_stage && events_in.data_ack_lost)
      |=> usb_irq_line_one_out;
  endproperty
  a_lost_ack_line: assert property (p_lost_ack_line) else $error("lost ack stage silent");
  property p_token_clears;
    s_stage_then_token |=> usb_irq_line_one_out;
  endproperty
  a_token_clears: assert property (p_token_clears) else $error("token left stage flag");
  property p_tx_drop;
    events_in.status_stage && events_in.data_ack_lost && events_in.ctrl_read
      && events_in.tx_buf_cleared |=> !ep0_transmit_ready_out;
  endproperty
  a_tx_drop: assert property (p_tx_drop) else $error("transmit ready not dropped");
  property p_two_write;
    s_axi_awvalid && s_axi_awready && s_axi_awaddr == ep0_irq_pkg::OFF_STATUS_TWO
      |-> ##[1:4] (s_axi_bvalid && s_axi_bresp == ep0_irq_pkg::RESP_SLVERR);
  endproperty
  a_two_write: assert property (p_two_write) else $error("status two took a write");
  property p_two_read;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == ep0_irq_pkg::OFF_STATUS_TWO
      |-> ##[1:4] (s_axi_rvalid && s_axi_rresp == ep0_irq_pkg::RESP_OKAY
      && s_axi_rdata[31:8] == 24'h000000 && s_axi_rdata[3:0] == 4'h0);
  endproperty
  a_two_read: assert property (p_two_read) else $error("status two read malformed");
  property p_line_one_cause;
    usb_irq_line_one_out |-> $past(events_in.setup_token || events_in.setup_data_ok
      || events_in.status_stage) || s_axi_bvalid || $past(s_axi_bvalid)
      || s_axi_rvalid || $past(s_axi_rvalid);
  endproperty
  a_line_one_cause: assert property (p_line_one_cause) else $error("line one uncaused");
  property p_line_two_cause;
    usb_irq_line_two_out |-> $past(events_in.bulk_in_nak || events_in.bulk_data_done)
      || s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_line_two_cause: assert property (p_line_two_cause) else $error("line two uncaused");
  property p_irq_rise;
    $rose(irq_out) |-> usb_irq_line_one_out || usb_irq_line_two_out
      || s_axi_bvalid || $past(s_axi_bvalid);
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose uncaused");
endmodule // ep0_irq_properties

bind ep0_control_irq ep0_irq_properties props (.*);
`default_nettype wire

// [usb_ep0_control_irq_status_test.sv]
/* Self-checking bench for ep0_control_irq driven by a USB host model.
   Assumes the package, host model and property checker compile first. */
`timescale 1ns/1ps
`default_nettype none
module usb_ep0_control_irq_status_test;
  localparam logic [63:0] SETUP_DATA = 64'h8877665544332211;
  logic                     clk_sys_in = 1'b0;
  logic                     reset_in = 1'b1;
  ep0_irq_pkg::usb_events_t events_in;
  logic [63:0]              setup_bytes_in;
  logic [7:0]               s_axi_awaddr = 8'h00;
  logic [7:0]               s_axi_araddr = 8'h00;
  logic [31:0]              s_axi_wdata = 32'h00000000;
  logic [3:0]               s_axi_wstrb = 4'hF;
  logic                     s_axi_awvalid = 1'b0;
  logic                     s_axi_wvalid = 1'b0;
  logic                     s_axi_arvalid = 1'b0;
  logic                     s_axi_bready = 1'b1;
  logic                     s_axi_rready = 1'b1;
  logic [2:0]               kind = 3'h0;
  logic                     go = 1'b0;
  logic                     s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic                     s_axi_rvalid, ep0_transmit_ready_out, irq_out;
  logic                     usb_irq_line_one_out, usb_irq_line_two_out;
  logic [1:0]               s_axi_bresp, s_axi_rresp;
  logic [31:0]              s_axi_rdata;
  int                       bad_count = 0;
  int                       n_compared = 0;

  always #4 clk_sys_in = ~clk_sys_in;

  usb_host_model #(.SETUP_DATA(SETUP_DATA)) host_i (.clk_sys_in, .reset_in,
    .kind_in(kind), .go_in(go), .events_out(events_in), .bytes_out(setup_bytes_in));
  ep0_control_irq dut (.*);

  // ************************************************
  // Shared tasks
  // ************************************************
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic hang;
    chk("bus wait", 32'h0, 32'h1);
    give_verdict;
  endtask
  // A bad access expects the slave error code, a good one the okay code
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic bad);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 40) hang;
    chk("bresp", 32'(s_axi_bresp),
        32'(bad ? ep0_irq_pkg::RESP_SLVERR : ep0_irq_pkg::RESP_OKAY));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic bad);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 40; n++) begin
      @(posedge clk_sys_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 40) hang;
    chk("rdata", s_axi_rdata, d);
    chk("rresp", 32'(s_axi_rresp),
        32'(bad ? ep0_irq_pkg::RESP_SLVERR : ep0_irq_pkg::RESP_OKAY));
  endtask
  task automatic host(input logic [2:0] k);
    kind <= k;
    go <= 1'b1;
    @(posedge clk_sys_in) go <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
  endtask
  // Pins are read after the wait, not when the task is called
  task automatic pin(input logic [1:0] exp);
    repeat (2) @(posedge clk_sys_in);
    chk("tx_ready irq_out", 32'({ep0_transmit_ready_out, irq_out}), 32'(exp));
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_reset;
    rd(ep0_irq_pkg::OFF_STATUS_ONE, 32'h0, 1'b0);
    rd(ep0_irq_pkg::OFF_STATUS_TWO, 32'h0, 1'b0);
    rd(ep0_irq_pkg::OFF_CONTROL, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(8'h20, 32'hFF, 1'b1);
    wr(ep0_irq_pkg::OFF_STATUS_ONE, 32'hFF, 1'b1);
    $display("done reset and decode");
  endtask
  task automatic t_nodata;
    int i;
    wr(ep0_irq_pkg::OFF_IRQ_MASK, 32'h3, 1'b0);
    host(3'h0);
    rd(ep0_irq_pkg::OFF_STATUS_ONE, 32'h7, 1'b0);
    pin(2'b01);
    for (i = 0; i < 8; i++) begin
      rd(ep0_irq_pkg::OFF_SETUP_BUF, 32'(SETUP_DATA[8*i+:8]), 1'b0);
      if (i == 0) rd(ep0_irq_pkg::OFF_STATUS_ONE, 32'h5, 1'b0);
    end
    rd(ep0_irq_pkg::OFF_STATUS_ONE, 32'h4, 1'b0);
    host(3'h1);
    rd(ep0_irq_pkg::OFF_STATUS_ONE, 32'h2, 1'b0);
    wr(ep0_irq_pkg::OFF_CLEAR_ONE, 32'h0, 1'b0);
    rd(ep0_irq_pkg::OFF_STATUS_ONE, 32'h0, 1'b0);
    wr(ep0_irq_pkg::OFF_IRQ_STATUS, 32'h3, 1'b0);
    pin(2'b00);
    $display("done no-data transfer");
  endtask
  task automatic t_lost;
    wr(ep0_irq_pkg::OFF_CONTROL, 32'h3, 1'b0);
    pin(2'b10);
    host(3'h2);
    pin(2'b01);
    rd(ep0_irq_pkg::OFF_CONTROL, 32'h2, 1'b0);
    rd(ep0_irq_pkg::OFF_STATUS_ONE, 32'h7, 1'b0);
    wr(ep0_irq_pkg::OFF_CLEAR_ONE, 32'h0, 1'b0);
    $display("done lost acknowledge");
  endtask
  task automatic t_two;
    host(3'h3);
    rd(ep0_irq_pkg::OFF_STATUS_TWO, 32'h20, 1'b0);
    host(3'h4);
    rd(ep0_irq_pkg::OFF_STATUS_TWO, 32'h30, 1'b0);
    wr(ep0_irq_pkg::OFF_STATUS_TWO, 32'h0, 1'b1);
    wr(ep0_irq_pkg::OFF_CLEAR_TWO, 32'hEF, 1'b0);
    rd(ep0_irq_pkg::OFF_STATUS_TWO, 32'h20, 1'b0);
    pin(2'b01);
    wr(ep0_irq_pkg::OFF_CONTROL, 32'h0, 1'b0);
    rd(ep0_irq_pkg::OFF_STATUS_TWO, 32'h0, 1'b0);
    wr(ep0_irq_pkg::OFF_IRQ_MASK, 32'h0, 1'b0);
    pin(2'b00);
    rd(ep0_irq_pkg::OFF_IRQ_STATUS, 32'h3, 1'b0);
    wr(ep0_irq_pkg::OFF_IRQ_STATUS, 32'h3, 1'b0);
    rd(ep0_irq_pkg::OFF_IRQ_STATUS, 32'h0, 1'b0);
    $display("done status two");
  endtask

  initial begin
    repeat (8) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    @(posedge clk_sys_in);
    t_reset;
    t_nodata;
    t_lost;
    t_two;
    give_verdict;
  end
endmodule // usb_ep0_control_irq_status_test
`default_nettype wire

// [usb_host_model.sv]
/* USB host side: plays one transfer as a train of engine event pulses.
   Assumes go_in is a one-cycle pulse on clk_sys_in. */
`timescale 1ns/1ps
`default_nettype none
module usb_host_model #(
  parameter logic [63:0] SETUP_DATA = 64'h0000000000000000
) (
  input  wire logic                    clk_sys_in, // System clock
  input  wire logic                    reset_in,   // Async reset
  input  wire logic [2:0]              kind_in,    // Transfer kind
  input  wire logic                    go_in,      // Start pulse
  output var ep0_irq_pkg::usb_events_t events_out, // Event pulses
  output var logic [63:0]              bytes_out   // Setup packet
);
  logic [26:0] seq_r;
  // Three cycles per transfer so SETUP, data and status never overlap
  function automatic logic [26:0] plan(input logic [2:0] k);
    case (k)
      3'h0: plan = {9'h100, 9'h0C0, 9'h020};
      3'h1: plan = {9'h020, 9'h100, 9'h080};
      3'h2: plan = {9'h100, 9'h0C0, 9'h03C};
      3'h3: plan = {9'h002, 9'h000, 9'h000};
      default: plan = {9'h001, 9'h000, 9'h000};
    endcase
  endfunction
  always_ff @(posedge clk_sys_in or posedge reset_in) begin
    if (reset_in) seq_r <= 27'h0000000;
    else if (go_in) seq_r <= plan(kind_in);
    else seq_r <= {seq_r[17:0], 9'h000};
  end
  assign events_out = ep0_irq_pkg::usb_events_t'(seq_r[26:18]);
  assign bytes_out  = SETUP_DATA;
endmodule // usb_host_model
`default_nettype wire
